// ---- verilog/rtcp_cfg.svh ----
// constants of the clock chip bus port: timing figures and widths
// assumes a single 125 MHz system clock
`ifndef RTCP_CFG_SVH
`define RTCP_CFG_SVH

`define RTCP_CLK_PERIOD_NS   8
`define RTCP_DATA_W          8
`define RTCP_CNT_W           6
// least widths of each bus phase, in ns
`define RTCP_AS_HIGH_NS      80
`define RTCP_ADDR_HOLD_NS    40
`define RTCP_DS_HIGH_NS      160
`define RTCP_RW_HOLD_NS      40
// timebase: oscillator edges per second tick
`define RTCP_OSC_HZ          32768
`define RTCP_SEC_CNT_W       15
`define RTCP_SEC_LAST        15'h7FFF

`endif

// ---- verilog/rtcp_pkg.sv ----
// types and helpers of the clock chip bus port
// assumes rtcp_cfg.svh is on the include path
`default_nettype none
`include "rtcp_cfg.svh"

package rtcp_pkg;

    // one-hot bus cycle states
    typedef enum logic [4:0] {
        RTCP_IDLE  = 5'h01,
        RTCP_ADDR  = 5'h02,
        RTCP_AHOLD = 5'h04,
        RTCP_DSTB  = 5'h08,
        RTCP_RECOV = 5'h10
    } rtcp_state_e;

    typedef struct packed {
        logic                    write;
        logic [`RTCP_DATA_W-1:0] addr;
        logic [`RTCP_DATA_W-1:0] wdata;
    } rtcp_req_s;

    typedef struct packed {
        logic                    addr_strobe;
        logic                    data_strobe;
        logic                    read_write;
        logic                    ctl_oe;
        logic [`RTCP_DATA_W-1:0] ad_out;
        logic                    ad_oe;
    } rtcp_pins_s;

    typedef struct packed {
        rtcp_state_e               st;
        logic [`RTCP_CNT_W-1:0]    cnt;
        rtcp_req_s                 req;
        logic [`RTCP_DATA_W-1:0]   rdata;
        logic                      rdata_valid;
        logic                      power_lost;
        logic                      osc_prev;
        logic [`RTCP_SEC_CNT_W-1:0] sec_cnt;
        logic                      osc_tick;
        logic                      sec_tick;
        logic                      irq;
    } rtcp_regs_s;

    // least time in ns to whole clock cycles, rounded up, at least one
    function automatic logic [`RTCP_CNT_W-1:0] rtcp_cycles(input int ns);
        int c;
        c = (ns + `RTCP_CLK_PERIOD_NS - 1) / `RTCP_CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[`RTCP_CNT_W-1:0];
    endfunction

endpackage : rtcp_pkg

`default_nettype wire

// ---- verilog/rtcp_sync.sv ----
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none

module rtcp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;

    always_ff @(posedge i_sys_clk) begin
        meta_q <= i_async;
        o_sync <= meta_q;
    end

endmodule // rtcp_sync

`default_nettype wire

// ---- verilog/rtcp_bus_port.sv ----
// clock chip bus port: multiplexed strobe bus to an external clock/RAM
// chip, timebase from the oscillator pin, power-loss and supply gating
// assumes one 125 MHz clock; host request port is on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "rtcp_cfg.svh"

// What this block does
// - power-loss reset forces the control state to its initial condition
// - power-loss reset low sets a sticky power-lost status bit
// - time-keeping ticks derive from the 32.768 kHz oscillator input
// - with external clock chip enabled, oscillator pin is clock interrupt
// - supply good low disconnects bus pins and ignores host accesses
// - address strobe high with valid address; falling edge latches it
// - read: read/write high, data strobe high, chip drives read data
// - write: data held valid through data strobe trailing edge
// - read/write line high for reads, low for writes
module rtcp_bus_port
    import rtcp_pkg::*;
(
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset_n,
    // pins
    input  wire logic                    i_power_loss_reset_n,
    input  wire logic                    i_osc_or_clock_irq_in,
    input  wire logic                    i_supply_good,
    input  wire logic [`RTCP_DATA_W-1:0] i_ad_in,
    output logic      [`RTCP_DATA_W-1:0] o_ad_out,
    output logic                         o_ad_oe,
    output logic                         o_clock_chip_addr_strobe,
    output logic                         o_clock_chip_data_strobe,
    output logic                         o_clock_chip_read_write,
    output logic                         o_ctl_oe,
    // configuration and status
    input  wire logic                    i_ext_clock_en,
    input  wire logic                    i_power_lost_clr,
    output logic                         o_power_lost,
    output logic                         o_timebase_tick,
    output logic                         o_seconds_tick,
    output logic                         o_clock_interrupt_request,
    // host request port
    input  wire logic                    i_req_valid,
    input  wire logic                    i_req_write,
    input  wire logic [`RTCP_DATA_W-1:0] i_req_addr,
    input  wire logic [`RTCP_DATA_W-1:0] i_req_wdata,
    output logic                         o_req_ready,
    output logic      [`RTCP_DATA_W-1:0] o_rdata,
    output logic                         o_rdata_valid
);

    // ------------------------------------------------------------
    // phase lengths
    // ------------------------------------------------------------
    localparam logic [`RTCP_CNT_W-1:0] AS_CYC =
        rtcp_cycles(`RTCP_AS_HIGH_NS);
    localparam logic [`RTCP_CNT_W-1:0] AH_CYC =
        rtcp_cycles(`RTCP_ADDR_HOLD_NS);
    localparam logic [`RTCP_CNT_W-1:0] DS_CYC =
        rtcp_cycles(`RTCP_DS_HIGH_NS);
    localparam logic [`RTCP_CNT_W-1:0] RW_CYC =
        rtcp_cycles(`RTCP_RW_HOLD_NS);
    localparam logic [`RTCP_CNT_W-1:0] CNT_ONE =
        {{(`RTCP_CNT_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = `RTCP_DATA_W + 3;
    logic [SW-1:0] sync_w;
    logic [`RTCP_DATA_W-1:0] ad_s;
    logic psrst_n_s;
    logic osc_s;
    logic good_s;

    rtcp_sync #(.W(SW)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_async   ({i_ad_in, i_power_loss_reset_n,
                     i_osc_or_clock_irq_in, i_supply_good}),
        .o_sync    (sync_w)
    );

    assign ad_s      = sync_w[SW-1:3];
    assign psrst_n_s = sync_w[2];
    assign osc_s     = sync_w[1];
    assign good_s    = sync_w[0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rtcp_regs_s r_q;
    rtcp_regs_s r_d;
    logic       take;
    logic       last;

    assign last        = (r_q.cnt == CNT_ONE);
    assign o_req_ready = (r_q.st == RTCP_IDLE) && good_s
                         && psrst_n_s;
    assign take        = o_req_ready && i_req_valid;

    always_comb begin
        r_d             = r_q;
        r_d.rdata_valid = 1'b0;
        r_d.osc_tick    = 1'b0;
        r_d.sec_tick    = 1'b0;
        if (!last) begin
            r_d.cnt = r_q.cnt - CNT_ONE;
        end

        // bus cycle sequencer
        case (r_q.st)
            RTCP_IDLE: begin
                if (take) begin
                    r_d.req.write = i_req_write;
                    r_d.req.addr  = i_req_addr;
                    r_d.req.wdata = i_req_wdata;
                    r_d.st        = RTCP_ADDR;
                    r_d.cnt       = AS_CYC;
                end
            end
            RTCP_ADDR: begin
                if (last) begin
                    r_d.st  = RTCP_AHOLD;
                    r_d.cnt = AH_CYC;
                end
            end
            RTCP_AHOLD: begin
                if (last) begin
                    r_d.st  = RTCP_DSTB;
                    r_d.cnt = DS_CYC;
                end
            end
            RTCP_DSTB: begin
                if (last) begin
                    if (!r_q.req.write) begin
                        r_d.rdata       = ad_s;
                        r_d.rdata_valid = 1'b1;
                    end
                    r_d.st  = RTCP_RECOV;
                    r_d.cnt = RW_CYC;
                end
            end
            RTCP_RECOV: begin
                if (last) begin
                    r_d.st = RTCP_IDLE;
                end
            end
            default: begin
                r_d.st = RTCP_IDLE;
            end
        endcase

        // supply loss drops any cycle in progress
        if (!good_s) begin
            r_d.st          = RTCP_IDLE;
            r_d.rdata_valid = 1'b0;
        end

        // oscillator pin: timebase or clock interrupt
        r_d.osc_prev = osc_s;
        if (i_ext_clock_en) begin
            r_d.irq = osc_s;
        end else begin
            r_d.irq = 1'b0;
            if (osc_s && !r_q.osc_prev) begin
                r_d.osc_tick = 1'b1;
                r_d.sec_cnt  = r_q.sec_cnt + 1'b1;
                if (r_q.sec_cnt == `RTCP_SEC_LAST) begin
                    r_d.sec_tick = 1'b1;
                end
            end
        end

        // power-lost flag: set wins over clear
        if (i_power_lost_clr) begin
            r_d.power_lost = 1'b0;
        end
        if (!psrst_n_s) begin
            r_d.power_lost  = 1'b1;
            r_d.st          = RTCP_IDLE;
            r_d.rdata_valid = 1'b0;
            r_d.cnt        = '0;
            r_d.req        = '0;
            r_d.rdata      = '0;
            r_d.sec_cnt    = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            r_q            <= '0;
            r_q.st         <= RTCP_IDLE;
            r_q.power_lost <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    rtcp_pins_s pins;

    always_comb begin
        pins             = '0;
        pins.read_write  = 1'b1;
        pins.ctl_oe      = good_s;
        pins.ad_out      = r_q.req.addr;
        case (r_q.st)
            RTCP_ADDR: begin
                pins.addr_strobe = 1'b1;
                pins.ad_oe       = good_s;
                pins.read_write  = !r_q.req.write;
            end
            RTCP_AHOLD: begin
                pins.ad_oe      = good_s;
                pins.read_write = !r_q.req.write;
            end
            RTCP_DSTB: begin
                pins.data_strobe = 1'b1;
                pins.read_write  = !r_q.req.write;
                pins.ad_out      = r_q.req.wdata;
                pins.ad_oe       = good_s && r_q.req.write;
            end
            RTCP_RECOV: begin
                pins.read_write = !r_q.req.write;
                pins.ad_out     = r_q.req.wdata;
                pins.ad_oe      = good_s && r_q.req.write;
            end
            default: begin
                pins.ad_out = r_q.req.addr;
            end
        endcase
    end

    assign o_clock_chip_addr_strobe  = pins.addr_strobe;
    assign o_clock_chip_data_strobe  = pins.data_strobe;
    assign o_clock_chip_read_write   = pins.read_write;
    assign o_ctl_oe                  = pins.ctl_oe;
    assign o_ad_out                  = pins.ad_out;
    assign o_ad_oe                   = pins.ad_oe;
    assign o_power_lost              = r_q.power_lost;
    assign o_timebase_tick           = r_q.osc_tick;
    assign o_seconds_tick            = r_q.sec_tick;
    assign o_clock_interrupt_request = r_q.irq;
    assign o_rdata                   = r_q.rdata;
    assign o_rdata_valid             = r_q.rdata_valid;

endmodule // rtcp_bus_port

`default_nettype wire

// ---- verif/rtcp_bus_port_monitor.sv ----
// checker of the clock chip strobe bus and host handshake
// assumes binding to rtcp_bus_port on its single clock
`timescale 1ns/1ps
`default_nettype none
module rtcp_bus_port_monitor (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_power_loss_reset_n,
    input wire logic i_supply_good,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic o_req_ready,
    input wire logic o_ad_oe,
    input wire logic o_ctl_oe,
    input wire logic o_clock_chip_addr_strobe,
    input wire logic o_clock_chip_data_strobe,
    input wire logic o_clock_chip_read_write,
    input wire logic o_rdata_valid,
    input wire logic o_power_lost
);
    // ----
    // checks
    // ----
    wire logic astb = o_clock_chip_addr_strobe;
    wire logic dstb = o_clock_chip_data_strobe;
    wire logic rw   = o_clock_chip_read_write;
    wire logic take = i_req_valid && o_req_ready;
    // aborts by supply or power loss end a cycle early
    wire logic run  = i_supply_good && i_power_loss_reset_n;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence as_gap_s;
        !dstb [*5] ##1 dstb;
    endsequence
    sequence ds_pulse_s;
        ##19 dstb ##1 !dstb;
    endsequence
    both_strobes_a: assert property (!(astb && dstb))
        else $error("both strobes high");
    strobe_gap_a: assert property (disable iff (!i_reset_n || !run)
        $fell(astb) |-> as_gap_s) else $error("bad address to data gap");
    ds_width_a: assert property (disable iff (!i_reset_n || !run)
        $rose(dstb) |-> ds_pulse_s) else $error("bad data strobe width");
    rw_stable_a: assert property (disable iff (!i_reset_n || !run)
        (dstb || $past(dstb)) |-> $stable(rw)) else $error("rw moved");
    rw_dir_a: assert property (take |->
        ##2 (rw == !$past(i_req_write, 2)))
        else $error("rw does not match request");
    read_answer_a: assert property (disable iff (!i_reset_n || !run)
        take && !i_req_write |-> ##[34:37] o_rdata_valid)
        else $error("read answer missing");
    bus_turn_a: assert property (dstb |-> (o_ad_oe == !rw))
        else $error("bus direction wrong in data phase");
    disconnect_a: assert property (!i_supply_good [*4] |->
        !(o_ad_oe || o_ctl_oe || o_req_ready)) else $error("not released");
    loss_idle_a: assert property (!i_power_loss_reset_n [*4] |->
        !astb && !dstb && rw && !o_req_ready && o_power_lost)
        else $error("power loss state wrong");
endmodule // rtcp_bus_port_monitor
`default_nettype wire

// ---- verif/rtcp_chip_model.sv ----
// behavioural clock/RAM chip on the multiplexed strobe bus
// assumes strobes and bus level sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module rtcp_chip_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_astb,
    input  wire logic       i_dstb,
    input  wire logic       i_rw,
    input  wire logic [7:0] i_bus,
    output logic      [7:0] o_data
);
    // ----
    // chip behaviour
    // ----
    logic [7:0] mem [256];
    logic [7:0] addr_q;
    logic       astb_q = 1'b0;
    logic       dstb_q = 1'b0;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        o_data = 8'h00;
    end
    // when not driving, data toggles so a released bus is never stale
    always @(posedge i_sys_clk) begin
        astb_q <= i_astb;
        dstb_q <= i_dstb;
        if (astb_q && !i_astb) addr_q <= i_bus;
        if (dstb_q && !i_dstb && !i_rw) mem[addr_q] <= i_bus;
        o_data <= (i_dstb && i_rw) ? mem[addr_q] : ~o_data;
    end
endmodule // rtcp_chip_model
`default_nettype wire

// ---- verif/rtcp_bus_port_test.sv ----
// self-checking bench of the clock chip bus port with a chip model
// assumes design, monitor and chip model compiled before it
`timescale 1ns/1ps
`default_nettype none
module rtcp_bus_port_test;
    // ----
    // stimulus and checks
    // ----
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic plr_n = 1'b1;
    logic osc = 1'b0;
    logic sg = 1'b1;
    logic ext_en = 1'b0;
    logic lost_clr = 1'b0;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ad_out, chip_data, rdata, bus;
    logic ad_oe, astb, dstb, rw, ctl_oe, lost, tick, sec, irq, ready, rv;
    int errors = 0;
    int n_tests = 0;
    int seed = 32'hE0A0;
    int cnt_tick = 0;
    int cnt_sec = 0;
    logic [7:0] exp_q [$];
    assign bus = ad_oe ? ad_out : chip_data;
    rtcp_bus_port dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_power_loss_reset_n(plr_n), .i_osc_or_clock_irq_in(osc),
        .i_supply_good(sg), .i_ad_in(bus), .o_ad_out(ad_out),
        .o_ad_oe(ad_oe), .o_clock_chip_addr_strobe(astb),
        .o_clock_chip_data_strobe(dstb), .o_clock_chip_read_write(rw),
        .o_ctl_oe(ctl_oe), .i_ext_clock_en(ext_en),
        .i_power_lost_clr(lost_clr), .o_power_lost(lost),
        .o_timebase_tick(tick), .o_seconds_tick(sec),
        .o_clock_interrupt_request(irq), .i_req_valid(valid),
        .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wdata),
        .o_req_ready(ready), .o_rdata(rdata), .o_rdata_valid(rv));
    rtcp_chip_model chip (.i_sys_clk(i_sys_clk), .i_astb(astb),
        .i_dstb(dstb), .i_rw(rw), .i_bus(bus), .o_data(chip_data));
    initial forever #4 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // request stays up; the caller lowers valid when done
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int k;
        valid = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        for (k = 0; k < 200 && ready !== 1'b1; k++) @(negedge i_sys_clk);
        if (k == 200) chk(16'h0, 16'h1);
        @(negedge i_sys_clk);
    endtask
    always @(posedge i_sys_clk) begin
        if (tick === 1'b1) cnt_tick++;
        if (sec === 1'b1) cnt_sec++;
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) chk(16'h1, 16'h0);
            else chk(rdata, exp_q.pop_front());
        end
    end
    initial begin
        logic [7:0] a [4];
        logic [7:0] d [4];
        logic [15:0] r;
        repeat (10) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        chk(lost, 1'b1);
        lost_clr = 1'b1;
        @(negedge i_sys_clk);
        lost_clr = 1'b0;
        chk(lost, 1'b0);
        // back-to-back writes then reads of the same places
        for (int i = 0; i < 8; i++) begin
            if (i < 4) begin
                r = 16'($random(seed));
                a[i] = {r[7:2], 2'(i)};
                d[i] = r[15:8];
            end else exp_q.push_back(d[i-4]);
            xfer(i < 4, a[i%4], d[i%4]);
        end
        valid = 1'b0;
        repeat (45) @(negedge i_sys_clk);
        // supply drops inside a read: no answer, pins released
        xfer(1'b0, a[0], 8'h00);
        valid = 1'b0;
        repeat (20) @(negedge i_sys_clk);
        sg = 1'b0;
        repeat (6) @(negedge i_sys_clk);
        chk({ready, ctl_oe, ad_oe}, 3'b000);
        sg = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        exp_q.push_back(d[0]);
        xfer(1'b0, a[0], 8'h00);
        valid = 1'b0;
        repeat (45) @(negedge i_sys_clk);
        plr_n = 1'b0;
        repeat (6) @(negedge i_sys_clk);
        chk({lost, ready, rw}, 3'b101);
        plr_n = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        for (int k = 0; k < 32770; k++) begin
            osc = 1'b1;
            @(negedge i_sys_clk);
            osc = 1'b0;
            @(negedge i_sys_clk);
        end
        repeat (5) @(negedge i_sys_clk);
        chk(16'(cnt_tick), 16'h8002);
        chk(16'(cnt_sec), 16'h0001);
        ext_en = 1'b1;
        osc = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        chk(irq, 1'b1);
        chk(16'(cnt_tick), 16'h8002);
        osc = 1'b0;
        repeat (6) @(negedge i_sys_clk);
        chk(irq, 1'b0);
        conclude();
    end
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        errors++;
        conclude();
    end
endmodule // rtcp_bus_port_test
bind rtcp_bus_port rtcp_bus_port_monitor mon (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_power_loss_reset_n(i_power_loss_reset_n),
    .i_supply_good(i_supply_good), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .o_req_ready(o_req_ready),
    .o_ad_oe(o_ad_oe), .o_ctl_oe(o_ctl_oe),
    .o_clock_chip_addr_strobe(o_clock_chip_addr_strobe),
    .o_clock_chip_data_strobe(o_clock_chip_data_strobe),
    .o_clock_chip_read_write(o_clock_chip_read_write),
    .o_rdata_valid(o_rdata_valid), .o_power_lost(o_power_lost));
`default_nettype wire
